/* File: inc/smr_pkg.sv */
// shared constants for the mode register write link
package smr_pkg;
  localparam int ADDR_W = 18;
  localparam int SEL_W  = 3;
  // register select codes on bank group bit zero and bank bits
  localparam logic [2:0] SEL_FIRST = 3'h1;
  localparam logic [2:0] SEL_FOURTH = 3'h4;
  localparam logic [2:0] SEL_FIFTH = 3'h5;
  localparam logic [2:0] SEL_SIXTH = 3'h6;
  localparam logic [2:0] SEL_EXT_WORD = 3'h7;
  // field positions
  localparam int CAL_LSB = 6;
  localparam int RDBI_BIT = 12;
  localparam int WDBI_BIT = 11;
  localparam int DMASK_BIT = 10;
  localparam int PERS_BIT = 9;
  localparam int PARK_LSB = 6;
  localparam int ODTPD_BIT = 5;
  localparam int PERR_BIT = 4;
  localparam int CERR_BIT = 3;
  localparam int PLAT_LSB = 0;
  localparam int CCD_LSB = 10;
  localparam int TRN_BIT = 7;
  localparam int RNG_BIT = 6;
  localparam int VAL_LSB = 0;
  localparam int NOM_LSB = 8;
  // reset value, and cycle codes for off and reserved settings
  localparam logic [17:0] CFG_RESET = 18'h00000;
  localparam logic [3:0] CYC_OFF = 4'h0;
  localparam logic [3:0] CYC_RSV = 4'hf;
  // reserved bit masks and highest legal codes
  localparam logic [17:0] RSV_TOP_MASK  = 18'h20000;
  localparam logic [17:0] RSV_MID_MASK  = 18'h02000;
  localparam logic [17:0] RSV_PAIR_MASK = 18'h00300;
  localparam logic [2:0]  PLAT_MAX      = 3'h4;
  localparam logic [2:0]  CCD_MAX       = 3'h4;
  localparam logic [2:0]  CAL_MAX       = 3'h5;
  localparam logic [5:0]  VAL_MAX       = 6'h32;
  // link timing: reference clock cycles per link clock half period; one command spans two half periods
  localparam int LINK_DIV = 4;
endpackage

/* File: inc/smr_if.sv */
// link between controller and device carrying mode register write commands
`timescale 1ns/1ps
`default_nettype none
interface smr_if;
  logic                    link_clk;
  logic                    cmd_n;
  logic [2:0]              sel;
  logic                    bg1;
  logic [17:0]             addr;
  modport ctrl (output link_clk, output cmd_n, output sel, output bg1, output addr);
  modport dev  (input link_clk, input cmd_n, input sel, input bg1, input addr);
endinterface
`default_nettype wire

/* File: rtl/smr_device.sv */
// device end: decodes mode register write commands into settings
`timescale 1ns/1ps
`default_nettype none
module smr_device
  import smr_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // link
  smr_if.dev               link,
  // error events from the data path
  input  wire logic        parity_err_evt,
  input  wire logic        crc_err_evt,
  // decoded settings
  output logic [3:0]       cs_latency,
  output logic             cs_latency_rsv,
  output logic             read_inversion_en,
  output logic             write_inversion_en,
  output logic             data_mask_en,
  output logic             persist_parity_en,
  output logic [2:0]       park_divisor,
  output logic             odt_buf_off_pd,
  output logic             parity_err_flag,
  output logic             crc_err_flag,
  output logic [3:0]       parity_latency,
  output logic             parity_latency_rsv,
  output logic [3:0]       long_col_spacing,
  output logic             long_col_spacing_rsv,
  output logic             vref_training_en,
  output logic             vref_range_two,
  output logic [5:0]       vref_value,
  output logic [17:0]      fifth_mode_register,
  output logic [17:0]      sixth_mode_register
);
  import smr_pkg::*;

  // ************************************************************
  // link sampling
  // ************************************************************
  logic [1:0]  clk_s_q;
  logic        clk_prev_q;
  logic [1:0]  cmd_s_q;
  logic [2:0]  sel_s1_q, sel_s2_q;
  logic [17:0] addr_s1_q, addr_s2_q;

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      clk_s_q    <= 2'h0;
      clk_prev_q <= 1'b0;
      cmd_s_q    <= 2'h3;
      sel_s1_q   <= 3'h0;
      sel_s2_q   <= 3'h0;
      addr_s1_q  <= 18'h00000;
      addr_s2_q  <= 18'h00000;
    end
    else
    begin
      clk_s_q    <= {clk_s_q[0], link.link_clk};
      clk_prev_q <= clk_s_q[1];
      cmd_s_q    <= {cmd_s_q[0], link.cmd_n};
      sel_s1_q   <= link.sel;
      sel_s2_q   <= sel_s1_q;
      addr_s1_q  <= link.addr;
      addr_s2_q  <= addr_s1_q;
    end

  // controller holds pins steady across the rising edge, so sampled copies agree
  wire rise      = clk_s_q[1] & ~clk_prev_q;
  wire cmd_take  = rise & ~cmd_s_q[1];
  // ext register control word code falls to no match and is dropped
  wire wr_fifth  = cmd_take & (sel_s2_q == SEL_FIFTH);
  wire wr_sixth  = cmd_take & (sel_s2_q == SEL_SIXTH);
  wire wr_fourth = cmd_take & (sel_s2_q == SEL_FOURTH);
  wire wr_first  = cmd_take & (sel_s2_q == SEL_FIRST);

  // ************************************************************
  // register storage
  // ************************************************************
  logic [17:0] fourth_mode_register_q, first_mode_register_q;
  logic        perr_q, cerr_q;

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      fifth_mode_register <= CFG_RESET;
      sixth_mode_register <= CFG_RESET;
      fourth_mode_register_q <= CFG_RESET;
      first_mode_register_q  <= CFG_RESET;
    end
    else
    begin
      if (wr_fifth)
        fifth_mode_register <= addr_s2_q;
      if (wr_sixth)
        sixth_mode_register <= addr_s2_q;
      if (wr_fourth)
        fourth_mode_register_q <= addr_s2_q;
      if (wr_first)
        first_mode_register_q <= addr_s2_q;
    end

  // event sets win over a clearing write in the same cycle
  wire perr_clr = wr_fifth & ~addr_s2_q[PERR_BIT];
  wire cerr_clr = wr_fifth & ~addr_s2_q[CERR_BIT];
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      perr_q <= 1'b0;
      cerr_q <= 1'b0;
    end
    else
    begin
      perr_q <= parity_err_evt | (perr_q & ~perr_clr);
      cerr_q <= crc_err_evt | (cerr_q & ~cerr_clr);
    end

  // ************************************************************
  // decode
  // ************************************************************
  function automatic logic [3:0] cal_cycles(input logic [2:0] c);
    case (c)
      3'h0: cal_cycles = CYC_OFF;
      3'h1: cal_cycles = 4'h3;
      3'h2: cal_cycles = 4'h4;
      3'h3: cal_cycles = 4'h5;
      3'h4: cal_cycles = 4'h6;
      3'h5: cal_cycles = 4'h8;
      default: cal_cycles = CYC_RSV;
    endcase
  endfunction

  function automatic logic [3:0] par_cycles(input logic [2:0] c);
    case (c)
      3'h0: par_cycles = CYC_OFF;
      3'h1: par_cycles = 4'h4;
      3'h2: par_cycles = 4'h5;
      3'h3: par_cycles = 4'h6;
      3'h4: par_cycles = 4'h8;
      default: par_cycles = CYC_RSV;
    endcase
  endfunction

  function automatic logic [2:0] park_div(input logic [2:0] c);
    case (c)
      3'h1: park_div = 3'h4;
      3'h2: park_div = 3'h2;
      3'h3: park_div = 3'h6;
      3'h4: park_div = 3'h1;
      3'h5: park_div = 3'h5;
      3'h6: park_div = 3'h3;
      3'h7: park_div = 3'h7;
      default: park_div = 3'h0;
    endcase
  endfunction

  wire [2:0] cal_code  = fourth_mode_register_q[CAL_LSB +: 3];
  wire [2:0] plat_code = fifth_mode_register[PLAT_LSB +: 3];
  wire [2:0] ccd_code  = sixth_mode_register[CCD_LSB +: 3];
  wire       nom_on    = |first_mode_register_q[NOM_LSB +: 3];

  assign cs_latency           = cal_cycles(cal_code);
  assign cs_latency_rsv       = (cal_code[2] & cal_code[1]);
  assign read_inversion_en    = fifth_mode_register[RDBI_BIT];
  assign write_inversion_en   = fifth_mode_register[WDBI_BIT];
  assign data_mask_en         = fifth_mode_register[DMASK_BIT];
  assign persist_parity_en    = fifth_mode_register[PERS_BIT];
  assign park_divisor         = park_div(fifth_mode_register[PARK_LSB +: 3]);
  assign odt_buf_off_pd       = nom_on & fifth_mode_register[ODTPD_BIT];
  assign parity_err_flag      = perr_q;
  assign crc_err_flag         = cerr_q;
  assign parity_latency       = par_cycles(plat_code);
  assign parity_latency_rsv   = plat_code[2] & (plat_code[1] | plat_code[0]);
  assign long_col_spacing     = (ccd_code > 3'h4) ? CYC_RSV : (4'h4 + {1'b0, ccd_code});
  assign long_col_spacing_rsv = (ccd_code > 3'h4);
  assign vref_training_en     = sixth_mode_register[TRN_BIT];
  assign vref_range_two       = sixth_mode_register[RNG_BIT];
  assign vref_value           = sixth_mode_register[VAL_LSB +: 6];
endmodule
`default_nettype wire

/* File: rtl/smr_controller.sv */
// controller end: issues mode register write commands over the link
`timescale 1ns/1ps
`default_nettype none
module smr_controller
  import smr_pkg::*;
#(
  parameter int DIV = LINK_DIV
)
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // user request
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_sel,
  input  wire logic [17:0] req_addr,
  output logic             req_ready,
  // link
  smr_if.ctrl              link
);
  import smr_pkg::*;

  typedef enum logic [1:0] {
    SMR_IDLE = 2'b00,
    SMR_LOW  = 2'b01,
    SMR_HIGH = 2'b10
  } smr_state_t;

  smr_state_t  st_q;
  logic [7:0]  div_q;
  logic        cmd_n_q;
  logic        clk_q;
  logic [2:0]  sel_q;
  logic [17:0] addr_q;

  wire tick = (div_q == 8'(DIV - 1));
  // reserved bits forced to zero before driving the pins
  wire        to_fifth = (req_sel == SEL_FIFTH);
  wire        to_sixth = (req_sel == SEL_SIXTH);
  wire [17:0] rsv_mask = RSV_TOP_MASK
                       | ((to_fifth | to_sixth) ? RSV_MID_MASK : 18'h00000)
                       | (to_sixth ? RSV_PAIR_MASK : 18'h00000);
  wire [17:0] clean    = req_addr & ~rsv_mask;
  // a reserved setting is dropped, not sent; the user gets no error back,
  // so software must keep to legal codes if every write has to land
  wire        plat_bad = to_fifth & (req_addr[PLAT_LSB +: 3] > PLAT_MAX);
  wire        ccd_bad  = to_sixth & (req_addr[CCD_LSB +: 3] > CCD_MAX);
  wire        vref_bad = to_sixth & (req_addr[VAL_LSB +: 6] > VAL_MAX);
  wire        cal_bad  = (req_sel == SEL_FOURTH) & (req_addr[CAL_LSB +: 3] > CAL_MAX);
  wire        legal    = ~(plat_bad | ccd_bad | vref_bad | cal_bad);

  assign req_ready = (st_q == SMR_IDLE);

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      st_q    <= SMR_IDLE;
      div_q   <= 8'h00;
      cmd_n_q <= 1'b1;
      clk_q   <= 1'b0;
      sel_q   <= 3'h0;
      addr_q  <= 18'h00000;
    end
    else
    begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      case (st_q)
        SMR_IDLE:
          if (req_valid && legal)
          begin
            st_q    <= SMR_LOW;
            div_q   <= 8'h00;
            cmd_n_q <= 1'b0;
            sel_q   <= req_sel;
            addr_q  <= clean;
          end
        SMR_LOW:
          if (tick)
          begin
            st_q  <= SMR_HIGH;
            clk_q <= 1'b1;
          end
        SMR_HIGH:
          if (tick)
          begin
            st_q    <= SMR_IDLE;
            clk_q   <= 1'b0;
            cmd_n_q <= 1'b1;
          end
        default: st_q <= SMR_IDLE;
      endcase
    end

  assign link.link_clk = clk_q;
  assign link.cmd_n    = cmd_n_q;
  assign link.sel      = sel_q;
  assign link.bg1      = 1'b0;
  assign link.addr     = addr_q;
endmodule
`default_nettype wire

/* File: testbench/smr_link_chk.sv */
// concurrent checks on the mode register write link
`timescale 1ns/1ps
`default_nettype none
module smr_link_chk
#(
  parameter int DIV = 4
)
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // link
  input wire logic        link_clk,
  input wire logic        cmd_n,
  input wire logic [2:0]  sel,
  input wire logic        bg1,
  input wire logic [17:0] addr
);
  // ****************
  // link properties
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic cmd;
  assign cmd = !cmd_n;
  AST_BG1_ZERO: assert property (cmd |-> !bg1) else $error("bank group bit one set");
  AST_RSV_HIGH: assert property (cmd && sel inside {3'h5, 3'h6} |-> !addr[17] && !addr[13])
    else $error("reserved address bit set");
  AST_RSV_SIX: assert property (cmd && sel == 3'h6 |-> addr[9:8] == 2'h0)
    else $error("reserved sixth bits set");
  AST_CMD_LEN: assert property ($fell(cmd_n) |-> cmd[*8] ##1 cmd_n)
    else $error("command length wrong");
  AST_HOLD: assert property (cmd && $past(cmd) |-> $stable(sel) && $stable(addr))
    else $error("command fields moved");
  AST_CLK_RISE: assert property ($fell(cmd_n) |-> !link_clk[*4] ##1 link_clk)
    else $error("link clock rise misplaced");
  AST_CMD_END: assert property ($fell(cmd_n) |-> ##DIV $rose(link_clk) ##DIV $rose(cmd_n))
    else $error("command end misplaced");
  AST_IDLE_CLK: assert property (cmd_n |-> !link_clk) else $error("link clock runs idle");
  AST_PLAT_LEGAL: assert property (cmd && sel == 3'h5 |-> addr[2:0] <= 3'h4)
    else $error("reserved parity latency sent");
  AST_CCD_LEGAL: assert property (cmd && sel == 3'h6 |-> addr[12:10] <= 3'h4)
    else $error("reserved column spacing sent");
  cover property ($fell(cmd_n) && sel == 3'h5);
  cover property ($fell(cmd_n) && sel == 3'h6);
  cover property ($fell(cmd_n) && sel == 3'h7);
endmodule
`default_nettype wire

/* File: testbench/sdram_mode_register_decode_tb.sv */
// self-checking bench for the mode register write link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end
module sdram_mode_register_decode_tb;
  import smr_pkg::*;
  // ****************
  // bench
  // ****************
  localparam logic [3:0] CAL_EXP [6] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
  localparam logic [3:0] PLAT_EXP [5] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8};
  localparam logic [2:0] PARK_EXP [8] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h5, 3'h3, 3'h7};
  logic        ref_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_ready;
  logic        parity_err_evt = 1'b0, crc_err_evt = 1'b0;
  logic [2:0]  req_sel = 3'h0, park_divisor;
  logic [17:0] req_addr = 18'h00000, a, fifth_mode_register, sixth_mode_register;
  logic [3:0]  cs_latency, parity_latency, long_col_spacing, m;
  logic        cs_latency_rsv, parity_latency_rsv, long_col_spacing_rsv;
  logic        read_inversion_en, write_inversion_en, data_mask_en, persist_parity_en;
  logic        odt_buf_off_pd, parity_err_flag, crc_err_flag, vref_training_en, vref_range_two;
  logic [5:0]  vref_value;
  int          fail_count = 0, total_checks = 0;
  smr_if u_link ();
  smr_controller #(.DIV(LINK_DIV)) u_smr_controller (.ref_clk, .reset_n, .req_valid, .req_sel,
    .req_addr, .req_ready, .link(u_link));
  smr_device u_smr_device (.ref_clk, .reset_n, .link(u_link), .parity_err_evt, .crc_err_evt,
    .cs_latency, .cs_latency_rsv, .read_inversion_en, .write_inversion_en, .data_mask_en, .persist_parity_en,
    .park_divisor, .odt_buf_off_pd, .parity_err_flag, .crc_err_flag, .parity_latency,
    .parity_latency_rsv, .long_col_spacing, .long_col_spacing_rsv, .vref_training_en,
    .vref_range_two, .vref_value, .fifth_mode_register, .sixth_mode_register);
  smr_link_chk #(.DIV(LINK_DIV)) u_smr_link_chk (.ref_clk, .reset_n, .link_clk(u_link.link_clk),
    .cmd_n(u_link.cmd_n), .sel(u_link.sel), .bg1(u_link.bg1), .addr(u_link.addr));
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // sample one step after the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 40 && req_ready !== 1'b1; k++)
      cyc(1);
    if (k == 40)
    begin
      fail_count++;
      $display("MISMATCH %0t ready timeout", $time);
      end_of_test;
    end
  endtask
  // device settles within a few cycles of the link clock rise
  task automatic send(input logic [2:0] s, input logic [17:0] v);
    wait_ready;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_sel <= s;
    req_addr <= v;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    wait_ready;
    cyc(3);
  endtask
  task automatic pulse(input logic crc);
    @(posedge ref_clk);
    parity_err_evt <= !crc;
    crc_err_evt <= crc;
    @(posedge ref_clk);
    parity_err_evt <= 1'b0;
    crc_err_evt <= 1'b0;
    cyc(2);
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    `CHK(fifth_mode_register, CFG_RESET)
    `CHK(parity_err_flag, 1'b0)
    for (int i = 0; i < 6; i++)
    begin
      send(SEL_FOURTH, 18'(i) << 6);
      `CHK(cs_latency, CAL_EXP[i])
      `CHK(cs_latency_rsv, 1'b0)
    end
    $display("latency test done");
    for (int i = 0; i < 8; i++)
    begin
      m = 4'((i * 3) & 15);
      a = {5'h00, m, 3'(i), 3'h0, 3'(i % 5)};
      send(SEL_FIFTH, a);
      `CHK({read_inversion_en, write_inversion_en, data_mask_en}, m[3:1])
      `CHK(persist_parity_en, m[0])
      `CHK(park_divisor, PARK_EXP[i])
      `CHK(parity_latency, PLAT_EXP[i % 5])
      `CHK(parity_latency_rsv, 1'b0)
      `CHK(fifth_mode_register, a)
    end
    $display("fifth register test done");
    send(SEL_FIRST, 18'h00000);
    send(SEL_FIFTH, 18'h00020);
    `CHK(odt_buf_off_pd, 1'b0)
    send(SEL_FIRST, 18'h00100);
    `CHK(odt_buf_off_pd, 1'b1)
    send(SEL_FIFTH, 18'h00000);
    `CHK(odt_buf_off_pd, 1'b0)
    send(SEL_EXT_WORD, 18'h01e3f);
    `CHK(fifth_mode_register, 18'h00000)
    `CHK(sixth_mode_register, 18'h00000)
    $display("termination and select test done");
    for (int i = 0; i < 5; i++)
    begin
      a = {5'h00, 3'(i), 2'h0, 1'(i), 1'(i >> 1), 6'(i * 12)};
      send(SEL_SIXTH, a);
      `CHK(long_col_spacing, 4'(i + 4))
      `CHK(long_col_spacing_rsv, 1'b0)
      `CHK({vref_training_en, vref_range_two}, a[7:6])
      `CHK(vref_value, 6'(i * 12))
      `CHK(sixth_mode_register, a)
    end
    $display("sixth register test done");
    // reserved bits reach the pins as zero
    send(SEL_FIFTH, 18'h23000);
    `CHK(fifth_mode_register, 18'h01000)
    `CHK(read_inversion_en, 1'b1)
    send(SEL_SIXTH, 18'h00345);
    `CHK(sixth_mode_register, 18'h00045)
    // reserved settings never reach the device
    send(SEL_FIFTH, 18'h00005);
    `CHK(fifth_mode_register, 18'h01000)
    send(SEL_SIXTH, 18'h01400);
    send(SEL_SIXTH, 18'h00033);
    `CHK(sixth_mode_register, 18'h00045)
    send(SEL_FOURTH, 18'h001c0);
    `CHK(cs_latency, CAL_EXP[5])
    $display("reserved setting test done");
    pulse(1'b0);
    `CHK({parity_err_flag, crc_err_flag}, 2'h2)
    pulse(1'b1);
    `CHK(crc_err_flag, 1'b1)
    send(SEL_FIFTH, 18'h00008);
    `CHK({parity_err_flag, crc_err_flag}, 2'h1)
    send(SEL_FIFTH, 18'h00000);
    `CHK(crc_err_flag, 1'b0)
    $display("error flag test done");
    end_of_test;
  end
endmodule
`default_nettype wire
